//--- write_crc_bc4_input_mapping_tb.sv
// Purpose: end-to-end bench for the chopped-burst write crc link
// Assumes: controller and device ends face each other on one link
// Notes:   a second link lets the bench corrupt or cut a burst on purpose
`timescale 1ns/100ps
`default_nettype none
module write_crc_bc4_input_mapping_tb;
   import write_crc_pkg::*;
   typedef struct {burst_data_type d; burst_mask_type m; logic a2; logic en;} burst_type;
   logic i_clock, i_sys_rst, wr_req, a2, dmi_en, busy, done;
   logic dev_en = 1'b0;
   logic valid, crc_err, valid2, err2, rx_a2;
   burst_data_type wr_data, rx_data;
   burst_mask_type wr_mask, rx_mask;
   crc_pair_type crc_calc, crc_recv;
   int mismatches, checked, seed, beat;
   burst_type exp_q[$], wire_q[$], cur, r;
   write_crc_link_if link ();
   write_crc_link_if bad_link ();

   write_crc_ctrl write_crc_ctrl_i (
      .i_clock(i_clock), .i_sys_rst(i_sys_rst), .i_wr_req(wr_req), .i_wr_data(wr_data),
      .i_wr_mask(wr_mask), .i_a2(a2), .i_dmi_enable(dmi_en), .o_busy(busy), .o_done(done),
      .link(link));
   write_crc_dev write_crc_dev_i (
      .i_clock(i_clock), .i_sys_rst(i_sys_rst), .i_dmi_enable(dev_en), .o_wr_valid(valid),
      .o_crc_error(crc_err), .o_wr_data(rx_data), .o_wr_mask(rx_mask), .o_a2(rx_a2),
      .o_crc_calc(crc_calc), .o_crc_recv(crc_recv), .link(link));
   write_crc_dev write_crc_dev_i2 (
      .i_clock(i_clock), .i_sys_rst(i_sys_rst), .i_dmi_enable(1'b0), .o_wr_valid(valid2),
      .o_crc_error(err2), .o_wr_data(), .o_wr_mask(), .o_a2(), .o_crc_calc(), .o_crc_recv(),
      .link(bad_link));
   write_crc_link_properties write_crc_link_properties_i (
      .i_clock(i_clock), .i_sys_rst(i_sys_rst), .i_dq_out(link.dq_out), .i_dq_oe(link.dq_oe),
      .i_dmi_out(link.dmi_out), .i_dmi_oe(link.dmi_oe), .i_strobe(link.strobe),
      .i_first(link.first), .i_a2(link.a2));

   // ----------------------------------------
   // expectations and reporting
   // ----------------------------------------
   function automatic crc_pair_type exp_crc(input burst_type b);
      logic [71:0] v;
      logic [7:0] c;
      crc_pair_type res;
      for (int t = 0; t < 2; t++) begin
         v = '1;
         for (int k = 0; k < 4; k++) begin
            for (int l = 0; l < 8; l++) v[l*8+k+4*b.a2] = b.d[k][t*8+l];
            if (b.en) v[64+k+4*b.a2] = b.m[k][t];
         end
         c = 8'h00;
         for (int i = 0; i < 72; i++) c = {c[6:0], 1'b0} ^ ((c[7] ^ v[i]) ? 8'h07 : 8'h00);
         res[t] = c;
      end
      return res;
   endfunction

   task automatic check(input logic [63:0] got, input logic [63:0] want);
      checked++;
      if (got !== want) begin
         mismatches++;
         $display("unexpected at %0t: got %h want %h", $time, got, want);
      end
   endtask

   task automatic wrap_up();
      if (mismatches == 0 && checked > 0) $display("Test passed");
      else $display("Test failed");
      $finish;
   endtask

   // request held high; the edge that sees busy low takes it
   task automatic wait_take();
      for (int i = 0; i < 20; i++) begin
         @(posedge i_clock);
         if (busy === 1'b0) return;
      end
      mismatches++;
      wrap_up();
   endtask

   // bench plays controller on the spare link, crc optionally flipped
   task automatic raw_burst(input burst_type b, input logic bad, input int nb);
      crc_pair_type c;
      logic seen;
      c = exp_crc(b);
      seen = 1'b0;
      for (int k = 0; k < nb; k++) begin
         bad_link.strobe <= 1'b1;
         bad_link.dq_oe <= 1'b1;
         bad_link.first <= (k == 0);
         bad_link.a2 <= b.a2;
         bad_link.dq_out <= (k < 4) ? b.d[k] : (k == 8) ? c ^ {15'h0000, bad} : 16'hffff;
         @(posedge i_clock);
      end
      bad_link.strobe <= 1'b0;
      bad_link.dq_oe <= 1'b0;
      bad_link.first <= 1'b0;
      bad_link.dq_out <= ~bad_link.dq_out;
      for (int i = 0; i < 8; i++) begin
         @(posedge i_clock);
         if (valid2 === 1'b1) begin
            seen = 1'b1;
            check(err2, bad);
         end
      end
      check(seen, nb == 10);
   endtask

   // ----------------------------------------
   // monitors
   // ----------------------------------------
   always @(posedge i_clock) begin
      if (link.strobe === 1'b1) begin
         beat = (link.first === 1'b1) ? 0 : beat + 1;
         if (link.first === 1'b1) dev_en <= wire_q[0].en;
         if (beat < 4) check(link.dq_out, wire_q[0].d[beat]);
         if (beat < 4) check(link.dmi_oe, wire_q[0].en);
         if (beat < 4 && wire_q[0].en) check(link.dmi_out, wire_q[0].m[beat]);
         if (beat >= 4 && beat != 8) check(link.dq_out, 16'hffff);
         if (beat == 8) check(link.dq_out, exp_crc(wire_q[0]));
         check(done, beat == 9);
         check(busy, beat != 9);
         if (beat == 9) void'(wire_q.pop_front());
      end
   end

   always @(posedge i_clock) begin
      if (valid === 1'b1) begin
         check(exp_q.size() > 0, 1'b1);
         if (exp_q.size() > 0) begin
            r = exp_q.pop_front();
            check(crc_err, 1'b0);
            check(crc_calc, exp_crc(r));
            check(crc_recv, exp_crc(r));
            check(rx_data, r.d);
            check(rx_mask, r.en ? r.m : 8'hff);
            check(rx_a2, r.a2);
         end
      end
   end

   initial begin
      i_clock = 1'b0;
      forever #25 i_clock = ~i_clock;
   end

   // ----------------------------------------
   // main sequence
   // ----------------------------------------
   initial begin
      seed = 58;
      mismatches = 0;
      checked = 0;
      i_sys_rst = 1'b1;
      wr_req = 1'b0;
      wr_data = '0;
      wr_mask = '0;
      a2 = 1'b0;
      dmi_en = 1'b0;
      bad_link.dq_out = '1;
      bad_link.dq_oe = 1'b0;
      bad_link.dmi_out = 2'b00;
      bad_link.dmi_oe = 1'b0;
      bad_link.strobe = 1'b0;
      bad_link.first = 1'b0;
      bad_link.a2 = 1'b0;
      repeat (20) @(posedge i_clock);
      i_sys_rst <= 1'b0;
      @(posedge i_clock);
      // zero data first: disabled mask lanes must still count as ones
      for (int n = 0; n < 24; n++) begin
         cur.d = (n < 4) ? '0 : {$random(seed), $random(seed)};
         cur.m = (n < 4) ? '0 : 8'($random(seed));
         cur.a2 = (n < 4) ? n[0] : 1'($random(seed));
         cur.en = (n < 4) ? n[1] : 1'($random(seed));
         wr_data <= cur.d;
         wr_mask <= cur.m;
         a2 <= cur.a2;
         dmi_en <= cur.en;
         wr_req <= 1'b1;
         wait_take();
         exp_q.push_back(cur);
         wire_q.push_back(cur);
      end
      wr_req <= 1'b0;
      for (int i = 0; i < 40 && exp_q.size() > 0; i++) @(posedge i_clock);
      check(exp_q.size(), 0);
      cur.en = 1'b0;
      raw_burst(cur, 1'b0, 10);
      raw_burst(cur, 1'b1, 10);
      raw_burst(cur, 1'b0, 6);
      wrap_up();
   end
endmodule // write_crc_bc4_input_mapping_tb
`default_nettype wire

//--- write_crc_ctrl.sv
// Purpose: controller end; sends one chopped write burst with its crc beat
// Assumes: caller holds request data stable only in the accepting cycle
// Notes:   crc is computed once at accept, over the mapped tree inputs
`timescale 1ns/100ps
`default_nettype none
module write_crc_ctrl (
   input wire logic i_clock,                              // 20 mhz clock
   input wire logic i_sys_rst,                            // sync reset, high
   input wire logic i_wr_req,                             // write request
   input wire write_crc_pkg::burst_data_type i_wr_data,   // four data beats
   input wire write_crc_pkg::burst_mask_type i_wr_mask,   // mask lane values
   input wire logic i_a2,                                 // burst start bit a2
   input wire logic i_dmi_enable,                         // mask or inversion on
   output logic o_busy,                                   // burst in progress
   output logic o_done,                                   // burst sent pulse
   write_crc_link_if.controller link                      // link to device
);
   import write_crc_pkg::*;

   // -------------------------------------------------------------
   // state
   // -------------------------------------------------------------
   typedef enum logic [1:0] {
      TX_IDLE = 2'b00,
      TX_SEND = 2'b01
   } tx_state_type;

   typedef struct packed {
      tx_state_type state;
      logic [BEAT_W-1:0] beat;
      burst_data_type data;
      burst_mask_type mask;
      logic dmi_en;
      logic a2;
      crc_pair_type crc;
      logic [DQ_W-1:0] dq;
      logic dq_oe;
      logic [TREES-1:0] dmi;
      logic dmi_oe;
      logic strobe;
      logic first;
      logic a2_out;
      logic busy;
      logic done;
   } tx_type;

   tx_type tx_reg;
   tx_type tx_next;

   // -------------------------------------------------------------
   // next state
   // -------------------------------------------------------------
   always_comb begin
      tx_next = tx_reg;
      tx_next.done = 1'b0;
      tx_next.strobe = 1'b0;
      tx_next.first = 1'b0;
      tx_next.dq_oe = 1'b0;
      tx_next.dmi_oe = 1'b0;
      tx_next.dq = '1;
      tx_next.dmi = '1;
      case (tx_reg.state)
         TX_IDLE: begin
            if (i_wr_req) begin
               tx_next.state = TX_SEND;
               tx_next.beat = BEAT_FIRST;
               tx_next.data = i_wr_data;
               tx_next.mask = i_wr_mask;
               tx_next.a2 = i_a2;
               tx_next.dmi_en = i_dmi_enable;
               tx_next.busy = 1'b1;
               for (int t = 0; t < TREES; t++) begin
                  tx_next.crc[t] = crc8(map_tree(split_tree(i_wr_data, i_wr_mask, t),
                                                 i_a2, i_dmi_enable));
               end
            end
         end
         TX_SEND: begin
            tx_next.strobe = 1'b1;
            tx_next.first = (tx_reg.beat == BEAT_FIRST);
            tx_next.a2_out = tx_reg.a2;
            tx_next.dq_oe = 1'b1;
            tx_next.dmi_oe = tx_reg.dmi_en;
            if (tx_reg.beat < BEAT_FILL) begin
               tx_next.dq = tx_reg.data[tx_reg.beat[1:0]];
               tx_next.dmi = tx_reg.dmi_en ? tx_reg.mask[tx_reg.beat[1:0]] : '1;
            end else if (tx_reg.beat == BEAT_CRC) begin
               tx_next.dq = tx_reg.crc;
            end
            tx_next.beat = tx_reg.beat + 4'h1;
            if (tx_reg.beat == BEAT_LAST) begin
               tx_next.state = TX_IDLE;
               tx_next.busy = 1'b0;
               tx_next.done = 1'b1;
            end
         end
         default: begin
            tx_next.state = TX_IDLE;
            tx_next.busy = 1'b0;
         end
      endcase
   end

   always_ff @(posedge i_clock) begin
      if (i_sys_rst) begin
         tx_reg <= '0;
      end else begin
         tx_reg <= tx_next;
      end
   end

   assign link.dq_out = tx_reg.dq;
   assign link.dq_oe = tx_reg.dq_oe;
   assign link.dmi_out = tx_reg.dmi;
   assign link.dmi_oe = tx_reg.dmi_oe;
   assign link.strobe = tx_reg.strobe;
   assign link.first = tx_reg.first;
   assign link.a2 = tx_reg.a2_out;
   assign o_busy = tx_reg.busy;
   assign o_done = tx_reg.done;

endmodule // write_crc_ctrl
`default_nettype wire

//--- write_crc_dev.sv
// Purpose: device end; captures a chopped write burst and checks its crc
// Assumes: link pins arrive from outside, so every link input is synchronised
// Notes:   a burst whose strobe drops early is dropped without a result
//          back-to-back bursts need one idle beat; the check state uses it
//          a cut burst leaves stale beats in capture, never in the outputs
`timescale 1ns/100ps
`default_nettype none
module write_crc_dev (
   input wire logic i_clock,                              // 20 mhz clock
   input wire logic i_sys_rst,                            // sync reset, high
   input wire logic i_dmi_enable,                         // mask or inversion on
   output logic o_wr_valid,                               // burst result pulse
   output logic o_crc_error,                              // crc mismatch pulse
   output write_crc_pkg::burst_data_type o_wr_data,       // captured data beats
   output write_crc_pkg::burst_mask_type o_wr_mask,       // captured mask lanes
   output logic o_a2,                                     // burst start bit a2
   output write_crc_pkg::crc_pair_type o_crc_calc,        // recomputed crc
   output write_crc_pkg::crc_pair_type o_crc_recv,        // crc from the link
   write_crc_link_if.device link                          // link from controller
);
   import write_crc_pkg::*;

   // -------------------------------------------------------------
   // state and link beat bundle
   // -------------------------------------------------------------
   typedef enum logic [1:0] {
      RX_IDLE = 2'b00,
      RX_RECV = 2'b01,
      RX_CHECK = 2'b11
   } rx_state_type;

   // one beat of the link pins, as the sync stages carry it
   typedef struct packed {
      logic strobe;
      logic first;
      logic a2;
      logic [TREES-1:0] dmi;
      logic [DQ_W-1:0] dq;
   } link_beat_type;

   typedef struct packed {
      // meta and sync: the two pin stages; only sync feeds logic
      link_beat_type meta;
      link_beat_type sync;
      rx_state_type state;
      logic [BEAT_W-1:0] beat;
      burst_data_type data;
      burst_mask_type mask;
      logic a2;
      logic dmi_en;
      crc_pair_type crc_rx;
      logic tail_ok;
      logic valid;
      logic error;
      crc_pair_type crc_calc;
      burst_data_type data_out;
      burst_mask_type mask_out;
      logic a2_out;
      crc_pair_type crc_out;
   } rx_type;

   rx_type rx_reg;
   rx_type rx_next;
   link_beat_type pin;
   link_beat_type cur;
   crc_pair_type crc_now;
   logic [TREES-1:0][TREE_BITS-1:0] tree_in;
   logic mask_tail_high;

   // -------------------------------------------------------------
   // pin sampling
   // -------------------------------------------------------------
   // a lane not driven reads high, as the terminated bus would
   always_comb begin
      pin.strobe = link.strobe;
      pin.first = link.first;
      pin.a2 = link.a2;
      if (link.dmi_oe) begin
         pin.dmi = link.dmi_out;
      end else begin
         pin.dmi = '1;
      end
      if (link.dq_oe) begin
         pin.dq = link.dq_out;
      end else begin
         pin.dq = '1;
      end
   end

   assign cur = rx_reg.sync;

   // -------------------------------------------------------------
   // tail beat checks
   // -------------------------------------------------------------
   // mask lanes high in crc beats
   assign mask_tail_high = (&cur.dmi) | ~rx_reg.dmi_en;

   // -------------------------------------------------------------
   // crc recomputation
   // -------------------------------------------------------------
   // taken from the held capture, so the trees get a whole cycle
   generate
      for (genvar t = 0; t < TREES; t++) begin : g_tree
         assign tree_in[t] = map_tree(split_tree(rx_reg.data, rx_reg.mask, t),
                                      rx_reg.a2, rx_reg.dmi_en);
         assign crc_now[t] = crc8(tree_in[t]);
      end
   endgenerate

   // -------------------------------------------------------------
   // next state
   // -------------------------------------------------------------
   always_comb begin
      rx_next = rx_reg;
      // two stages; only the second stage is read by logic
      rx_next.meta = pin;
      rx_next.sync = rx_reg.meta;
      rx_next.valid = 1'b0;
      rx_next.error = 1'b0;
      case (rx_reg.state)
         RX_IDLE: begin
            // beats without a first marker are ignored here
            if (cur.strobe && cur.first) begin
               rx_next.state = RX_RECV;
               rx_next.beat = BEAT_FIRST + 4'h1;
               rx_next.a2 = cur.a2;
               // enable taken with the first beat, held for the burst
               rx_next.dmi_en = i_dmi_enable;
               rx_next.tail_ok = 1'b1;
               rx_next.data[0] = cur.dq;
               rx_next.mask[0] = cur.dmi;
            end
         end
         RX_RECV: begin
            if (!cur.strobe || cur.first) begin
               // broken burst: nothing is reported for it
               // a new first here is not taken; the sender restarts after idle
               rx_next.state = RX_IDLE;
            end else begin
               if (rx_reg.beat < BEAT_FILL) begin
                  rx_next.data[rx_reg.beat[1:0]] = cur.dq;
                  rx_next.mask[rx_reg.beat[1:0]] = cur.dmi;
               end else if (rx_reg.beat == BEAT_CRC) begin
                  rx_next.crc_rx = cur.dq;
                  rx_next.tail_ok = rx_reg.tail_ok & mask_tail_high;
               end else if (rx_reg.beat == BEAT_LAST) begin
                  rx_next.tail_ok = rx_reg.tail_ok & (&cur.dq) & mask_tail_high;
                  rx_next.state = RX_CHECK;
               end
               rx_next.beat = rx_reg.beat + 4'h1;
            end
         end
         RX_CHECK: begin
            // compare recomputed crc
            // a tail fault raises the error pulse as a crc mismatch does
            rx_next.valid = 1'b1;
            rx_next.error = (crc_now != rx_reg.crc_rx) | ~rx_reg.tail_ok;
            rx_next.crc_calc = crc_now;
            rx_next.crc_out = rx_reg.crc_rx;
            rx_next.data_out = rx_reg.data;
            rx_next.mask_out = rx_reg.mask;
            rx_next.a2_out = rx_reg.a2;
            rx_next.state = RX_IDLE;
         end
         default: begin
            rx_next.state = RX_IDLE;
         end
      endcase
   end

   // sync stages clear too, so no stale first marker survives reset
   always_ff @(posedge i_clock) begin
      if (i_sys_rst) begin
         rx_reg <= '0;
      end else begin
         rx_reg <= rx_next;
      end
   end

   // -------------------------------------------------------------
   // outputs
   // -------------------------------------------------------------
   // data, mask, a2 and crc outputs stand until the next complete burst; valid and error pulse
   assign o_wr_valid = rx_reg.valid;
   assign o_crc_error = rx_reg.error;
   assign o_wr_data = rx_reg.data_out;
   assign o_wr_mask = rx_reg.mask_out;
   assign o_a2 = rx_reg.a2_out;
   assign o_crc_calc = rx_reg.crc_calc;
   assign o_crc_recv = rx_reg.crc_out;

endmodule // write_crc_dev
`default_nettype wire

//--- write_crc_link_if.sv
// Purpose: write link between controller end and device end
// Assumes: one beat per clock, controller is the only driver during writes
// Notes:   dq and mask lanes are two-way pins; only the write direction is used
`timescale 1ns/100ps
`default_nettype none
interface write_crc_link_if;
   import write_crc_pkg::*;
   logic [DQ_W-1:0] dq_out;
   logic dq_oe;
   logic [TREES-1:0] dmi_out;
   logic dmi_oe;
   logic strobe;
   logic first;
   logic a2;

   modport controller (
      output dq_out, dq_oe, dmi_out, dmi_oe, strobe, first, a2
   );
   modport device (
      input dq_out, dq_oe, dmi_out, dmi_oe, strobe, first, a2
   );
endinterface
`default_nettype wire

//--- write_crc_link_properties.sv
// Purpose: protocol checks on the controller-to-device write link
// Assumes: one clock domain, link watched as plain signals
// Notes:   data-dependent crc values are checked by the bench, not here
`timescale 1ns/100ps
`default_nettype none
module write_crc_link_properties (
   input wire logic i_clock,                               // link clock
   input wire logic i_sys_rst,                             // sync reset, high
   input wire logic [write_crc_pkg::DQ_W-1:0] i_dq_out,    // data lanes
   input wire logic i_dq_oe,                               // data lanes driven
   input wire logic [write_crc_pkg::TREES-1:0] i_dmi_out,  // mask lanes
   input wire logic i_dmi_oe,                              // mask lanes driven
   input wire logic i_strobe,                              // beat strobe
   input wire logic i_first,                               // first beat marker
   input wire logic i_a2                                   // burst start bit
);
   import write_crc_pkg::*;

   default clocking cb @(posedge i_clock);
   endclocking
   default disable iff (i_sys_rst);

   // ----------------------------------------
   // framing
   // ----------------------------------------
   a_frame_ten_beats:
   assert property (i_first |-> i_strobe[*8] ##1 i_strobe[*2] ##1 !i_strobe)
      else $error("burst is not ten beats then idle");
   a_single_first:
   assert property (i_first |=> (!i_first)[*8] ##1 !i_first)
      else $error("first marker repeated inside burst");
   a_start_marked:
   assert property ($rose(i_strobe) |-> i_first)
      else $error("burst starts without first marker");
   a_released_idle:
   assert property (!i_strobe |-> !i_dq_oe && !i_dmi_oe)
      else $error("lanes driven outside a burst");
   a_mask_within_data:
   assert property (i_dmi_oe |-> i_dq_oe)
      else $error("mask lanes driven without data lanes");
   a_a2_held:
   assert property (i_first |=> ($stable(i_a2))[*8] ##1 $stable(i_a2))
      else $error("start bit changed inside burst");

   // ----------------------------------------
   // fill and crc beats
   // ----------------------------------------
   a_fill_beats_ones:
   assert property (i_first |-> ##4 (i_dq_out == '1)[*4])
      else $error("fill beats not all ones");
   a_tail_beat_ones:
   assert property (i_first |-> ##9 i_dq_out == '1)
      else $error("last beat not all ones");
   a_mask_tail_ones:
   assert property (i_first && i_dmi_oe |-> ##8 (i_dmi_out == '1)[*2])
      else $error("mask lanes not ones in crc beats");

   c_low_half: cover property (i_first && !i_a2);
   c_high_half: cover property (i_first && i_a2);
   c_mask_on: cover property (i_first && i_dmi_oe);
   c_back_to_back: cover property (i_first ##11 i_first);
endmodule // write_crc_link_properties
`default_nettype wire

//--- write_crc_pkg.sv
// Purpose: shared constants, types and crc helpers for the chopped-burst write crc link
// Assumes: 16-bit organisation, two lane groups, one link beat per clock
// Notes:   both ends build the tree input with the same functions
package write_crc_pkg;

   // -------------------------------------------------------------
   // link and burst geometry
   // -------------------------------------------------------------
   localparam int DQ_W = 16;
   localparam int TREES = 2;
   localparam int LANE_W = 8;
   localparam int DATA_BEATS = 4;
   localparam int CRC_BEAT = 8;
   localparam int LAST_BEAT = 9;
   localparam int BEAT_W = 4;
   localparam int TREE_BITS = 72;
   localparam int MASK_LANE = 8;
   localparam int CRC_W = 8;
   localparam logic [BEAT_W-1:0] BEAT_FIRST = 4'h0;
   localparam logic [BEAT_W-1:0] BEAT_CRC = 4'h8;
   localparam logic [BEAT_W-1:0] BEAT_LAST = 4'h9;
   localparam logic [BEAT_W-1:0] BEAT_FILL = 4'h4;
   localparam logic [CRC_W-1:0] CRC_POLY = 8'h07;
   localparam logic [CRC_W-1:0] CRC_INIT = 8'h00;

   // -------------------------------------------------------------
   // types
   // -------------------------------------------------------------
   typedef logic [DATA_BEATS-1:0][DQ_W-1:0] burst_data_type;
   typedef logic [DATA_BEATS-1:0][TREES-1:0] burst_mask_type;
   typedef logic [DATA_BEATS-1:0][LANE_W:0] tree_beats_type;
   typedef logic [TREES-1:0][CRC_W-1:0] crc_pair_type;

   // one tree's slice: dq bits of its byte group plus its mask lane on top
   function automatic tree_beats_type split_tree(input burst_data_type d,
                                                 input burst_mask_type m, input int t);
      tree_beats_type b;
      b = '0;
      for (int k = 0; k < DATA_BEATS; k++) begin
         b[k] = {m[k][t], d[k][t*LANE_W +: LANE_W]};
      end
      return b;
   endfunction

   // 72-bit tree input: lane l bit p is index l*8+p, mask lane is lane 8
   function automatic logic [TREE_BITS-1:0] map_tree(input tree_beats_type b,
                                                    input logic a2, input logic dmi_en);
      logic [TREE_BITS-1:0] v;
      int lane;
      int pos;
      v = '1;
      for (int i = 0; i < TREE_BITS; i++) begin
         lane = i / LANE_W;
         pos = i % LANE_W;
         if (((pos >= DATA_BEATS) == a2) && (lane < MASK_LANE || dmi_en)) begin
            v[i] = b[pos % DATA_BEATS][lane];
         end
      end
      return v;
   endfunction

   // serial crc8, tree bit 0 shifted in first
   function automatic logic [CRC_W-1:0] crc8(input logic [TREE_BITS-1:0] v);
      logic [CRC_W-1:0] c;
      logic fb;
      c = CRC_INIT;
      for (int i = 0; i < TREE_BITS; i++) begin
         fb = c[CRC_W-1] ^ v[i];
         c = {c[CRC_W-2:0], 1'b0};
         if (fb) begin
            c = c ^ CRC_POLY;
         end
      end
      return c;
   endfunction

endpackage
